// ---- core/spx_pkg.sv ----
// shared constants for the selector privilege and coprocessor trap unit
package spx_pkg;

  // apb register byte offsets
  localparam logic [7:0] SPX_CTRL_OFS    = 8'h00;
  localparam logic [7:0] SPX_SEL_OFS     = 8'h04;
  localparam logic [7:0] SPX_ADJ_OFS     = 8'h08;
  localparam logic [7:0] SPX_INSN_OFS    = 8'h0C;
  localparam logic [7:0] SPX_STATUS_OFS  = 8'h10;
  localparam logic [7:0] SPX_CACHE_OFS   = 8'h14;

  // selector layout: requested privilege in the two low bits
  localparam int SPX_RQP_LSB      = 0;
  localparam int SPX_SEL_W        = 16;
  localparam int SPX_PRIV_W       = 2;

  // load command fields
  localparam int SPX_LD_TGT_LSB   = 16;
  localparam int SPX_LD_DPL_LSB   = 20;
  // adjust command: source selector in the upper half
  localparam int SPX_ADJ_SRC_LSB  = 16;
  // adjust result: zero flag position
  localparam int SPX_ADJ_ZF_BIT   = 16;

  // instruction command bits
  localparam int SPX_IN_WAITESC   = 0;
  localparam int SPX_IN_TSWITCH   = 1;
  localparam int SPX_IN_INTTASK   = 2;
  localparam int SPX_IN_BUSYTAS   = 3;
  localparam int SPX_IN_INTACK    = 4;
  localparam int SPX_IN_DESCFET   = 5;

  // status bits
  localparam int SPX_ST_TS        = 3;
  localparam int SPX_ST_PFAULT    = 0;
  localparam int SPX_ST_NMFAULT   = 1;
  localparam int SPX_ST_NUMERR    = 2;
  localparam int SPX_ST_LOCK      = 4;
  localparam int SPX_ST_ZF        = 5;
  localparam int SPX_ST_SWCNT_LSB = 8;

  // control: write one clears the task-switched flag
  localparam int SPX_CTRL_CLTS    = 0;

  // exception vectors
  localparam logic [7:0] SPX_VEC_NOEXT = 8'h07;

  // locked bus cycle counts
  localparam logic [3:0] SPX_LOCK_TAS_CYC  = 4'h3;
  localparam logic [3:0] SPX_LOCK_INTA_CYC = 4'h2;
  localparam logic [3:0] SPX_LOCK_DESC_CYC = 4'h4;

  // reset values
  localparam logic [31:0] SPX_ZERO_RST = 32'h0000_0000;

  typedef enum logic {SPX_LK_IDLE, SPX_LK_RUN} spx_lock_st_t;

endpackage

// ---- core/spx_trap_unit.sv ----
// selector privilege checks, privilege adjust, coprocessor trap and bus lock
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module spx_trap_unit
  import spx_pkg::*;
#(
  parameter int          NREG       = 6,
  parameter logic [7:0]  VEC_PROT   = 8'h0D,
  parameter logic [7:0]  VEC_NUMERR = 8'h10
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        npx_error,
  input  wire logic [11:0] mem_dpl,
  output logic             bus_lock,
  output logic             exc_valid,
  output logic [7:0]       exc_vector,
  output logic             npx_err_ack
);

  // elaboration check: index and descriptor bus widths serve six entries only
  if (NREG != 6)
  begin : g_bad_nreg
    $error("spx_trap_unit: NREG must be 6 (four segment, local table, task)");
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake
  logic        acc_w;
  logic        wr_fire;
  logic        rd_fire;
  logic        mapped_w;
  logic        stall_w;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_val;

  // one wait cycle, longer for an instruction write while a locked sequence is still running
  assign acc_w    = psel & penable & ~pready_r;
  assign mapped_w = (paddr == SPX_CTRL_OFS) | (paddr == SPX_SEL_OFS)
                  | (paddr == SPX_ADJ_OFS) | (paddr == SPX_INSN_OFS)
                  | (paddr == SPX_STATUS_OFS) | (paddr == SPX_CACHE_OFS);
  assign wr_fire  = psel & penable & pready_r & pwrite & mapped_w;
  assign rd_fire  = acc_w & ~pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  logic                  ts_r;
  logic                  pfault_r;
  logic                  nmfault_r;
  logic                  numerr_r;
  logic                  zf_r;
  logic [31:0]           adj_res_r;
  logic [2:0]            rd_idx_r;
  logic [7:0]            swcnt_r;
  logic [SPX_SEL_W-1:0]  sel_r [NREG];
  logic [SPX_PRIV_W-1:0] dpl_r [NREG];
  spx_lock_st_t          lk_st_r;
  logic [3:0]            lk_cnt_r;
  logic                  exc_valid_r;
  logic [7:0]            exc_vector_r;
  logic                  npx_ack_r;
  logic                  lock_out_r;

  // decoded command strobes
  logic                  ld_go;
  logic                  adj_go;
  logic                  insn_go;
  logic                  clts_go;
  logic                  tsw_go;
  logic [2:0]            ld_tgt;
  logic [SPX_PRIV_W-1:0] ld_rqp;
  logic [SPX_PRIV_W-1:0] ld_dpl;
  logic                  ld_ok;
  logic                  ld_bad;
  logic                  we_go;

  assign ld_go   = wr_fire & (paddr == SPX_SEL_OFS);
  assign adj_go  = wr_fire & (paddr == SPX_ADJ_OFS);
  assign insn_go = wr_fire & (paddr == SPX_INSN_OFS);
  assign clts_go = wr_fire & (paddr == SPX_CTRL_OFS) & pwdata[SPX_CTRL_CLTS];
  assign tsw_go  = insn_go & (pwdata[SPX_IN_TSWITCH] | pwdata[SPX_IN_INTTASK]);
  assign we_go   = insn_go & pwdata[SPX_IN_WAITESC];

  // selector load fields; unsigned compare keeps smaller value more privileged
  assign ld_tgt = pwdata[SPX_LD_TGT_LSB +: 3];
  assign ld_rqp = pwdata[SPX_RQP_LSB +: SPX_PRIV_W];
  assign ld_dpl = pwdata[SPX_LD_DPL_LSB +: SPX_PRIV_W];
  assign ld_ok  = ld_go & (ld_tgt < 3'(NREG)) & (ld_rqp <= ld_dpl);
  assign ld_bad = ld_go & (ld_tgt < 3'(NREG)) & (ld_rqp > ld_dpl);

  // locked sequence busy stalls further instruction writes
  assign stall_w = pwrite & (paddr == SPX_INSN_OFS) & (lk_st_r != SPX_LK_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // apb answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= acc_w & ~stall_w;
      pslverr_r <= acc_w & ~stall_w & ~mapped_w;
    end
  end

  // read mux
  always_comb
  begin
    rd_val = SPX_ZERO_RST;
    case (paddr)
      SPX_ADJ_OFS:    rd_val = adj_res_r;
      SPX_CTRL_OFS:   rd_val = {29'h0000_0000, rd_idx_r};
      SPX_STATUS_OFS:
      begin
        rd_val[SPX_ST_PFAULT]              = pfault_r;
        rd_val[SPX_ST_NMFAULT]             = nmfault_r;
        rd_val[SPX_ST_NUMERR]              = numerr_r;
        rd_val[SPX_ST_TS]                  = ts_r;
        rd_val[SPX_ST_LOCK]                = lock_out_r;
        rd_val[SPX_ST_ZF]                  = zf_r;
        rd_val[SPX_ST_SWCNT_LSB +: 8]      = swcnt_r;
      end
      SPX_CACHE_OFS:
      begin
        if (rd_idx_r < 3'(NREG))
        begin
          rd_val[SPX_SEL_W-1:0]               = sel_r[rd_idx_r];
          rd_val[SPX_LD_DPL_LSB +: SPX_PRIV_W] = dpl_r[rd_idx_r];
        end
      end
      default:        rd_val = SPX_ZERO_RST;
    endcase
  end

  // read data captured with the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= SPX_ZERO_RST;
    else if (rd_fire)
      prdata_r <= mapped_w ? rd_val : SPX_ZERO_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // selector load check and descriptor caches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_idx_r <= 3'h0;
    else if (ld_go)
      rd_idx_r <= ld_tgt;
    else if (wr_fire && paddr == SPX_CTRL_OFS)
      rd_idx_r <= pwdata[2:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_cache
      // entry changes only on its own load or a task switch reload
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sel_r[gi] <= 16'h0000;
          dpl_r[gi] <= 2'h0;
        end
        else if (tsw_go)
        begin
          dpl_r[gi] <= mem_dpl[gi*SPX_PRIV_W +: SPX_PRIV_W];
        end
        else if (ld_ok && ld_tgt == 3'(gi))
        begin
          sel_r[gi] <= pwdata[SPX_SEL_W-1:0];
          dpl_r[gi] <= ld_dpl;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // privilege adjust
  logic [SPX_PRIV_W-1:0] adj_dst;
  logic [SPX_PRIV_W-1:0] adj_src;
  logic [SPX_PRIV_W-1:0] adj_max;

  assign adj_dst = pwdata[SPX_RQP_LSB +: SPX_PRIV_W];
  assign adj_src = pwdata[SPX_ADJ_SRC_LSB +: SPX_PRIV_W];
  assign adj_max = (adj_src > adj_dst) ? adj_src : adj_dst;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adj_res_r <= SPX_ZERO_RST;
      zf_r      <= 1'b0;
    end
    else if (adj_go)
    begin
      adj_res_r <= {15'h0000, (adj_src > adj_dst),
                    pwdata[SPX_SEL_W-1:SPX_PRIV_W], adj_max};
      zf_r      <= (adj_src > adj_dst);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // task-switched flag: set wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ts_r <= 1'b0;
    else if (tsw_go)
      ts_r <= 1'b1;
    else if (clts_go)
      ts_r <= 1'b0;
  end

  // task switch counter; no coprocessor signal is driven by a switch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      swcnt_r <= 8'h00;
    else if (tsw_go)
      swcnt_r <= swcnt_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // exceptions: not-present trap, numeric error, protection fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exc_valid_r  <= 1'b0;
      exc_vector_r <= 8'h00;
      npx_ack_r    <= 1'b0;
    end
    else
    begin
      exc_valid_r <= 1'b0;
      npx_ack_r   <= 1'b0;
      if (ld_bad)
      begin
        exc_valid_r  <= 1'b1;
        exc_vector_r <= VEC_PROT;
      end
      else if (we_go && ts_r)
      begin
        exc_valid_r  <= 1'b1;
        exc_vector_r <= SPX_VEC_NOEXT;
      end
      else if (we_go && npx_error)
      begin
        exc_valid_r  <= 1'b1;
        exc_vector_r <= VEC_NUMERR;
        npx_ack_r    <= 1'b1;
      end
    end
  end

  // sticky status, cleared by writing ones to the status word
  logic st_clr;
  assign st_clr = wr_fire & (paddr == SPX_STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pfault_r  <= 1'b0;
      nmfault_r <= 1'b0;
      numerr_r  <= 1'b0;
    end
    else
    begin
      if (ld_bad)
        pfault_r <= 1'b1;
      else if (st_clr && pwdata[SPX_ST_PFAULT])
        pfault_r <= 1'b0;
      if (we_go && ts_r)
        nmfault_r <= 1'b1;
      else if (st_clr && pwdata[SPX_ST_NMFAULT])
        nmfault_r <= 1'b0;
      if (we_go && !ts_r && npx_error)
        numerr_r <= 1'b1;
      else if (st_clr && pwdata[SPX_ST_NUMERR])
        numerr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // locked bus sequences
  logic [3:0] lk_len;

  always_comb
  begin
    lk_len = 4'h0;
    if (pwdata[SPX_IN_BUSYTAS])
      lk_len = lk_len + SPX_LOCK_TAS_CYC;
    if (pwdata[SPX_IN_INTACK] || pwdata[SPX_IN_INTTASK])
      lk_len = lk_len + SPX_LOCK_INTA_CYC;
    if (pwdata[SPX_IN_DESCFET])
      lk_len = lk_len + SPX_LOCK_DESC_CYC;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_st_r    <= SPX_LK_IDLE;
      lk_cnt_r   <= 4'h0;
      lock_out_r <= 1'b0;
    end
    else
    begin
      case (lk_st_r)
        SPX_LK_IDLE:
        begin
          if (insn_go && lk_len != 4'h0)
          begin
            lk_st_r    <= SPX_LK_RUN;
            lk_cnt_r   <= lk_len;
            lock_out_r <= 1'b1;
          end
        end
        SPX_LK_RUN:
        begin
          if (lk_cnt_r == 4'h1)
          begin
            lk_st_r    <= SPX_LK_IDLE;
            lock_out_r <= 1'b0;
          end
          lk_cnt_r <= lk_cnt_r - 4'h1;
        end
        default:
        begin
          lk_st_r    <= SPX_LK_IDLE;
          lock_out_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign bus_lock    = lock_out_r;
  assign exc_valid   = exc_valid_r;
  assign exc_vector  = exc_vector_r;
  assign npx_err_ack = npx_ack_r;

endmodule

// ---- testbench/spx_chk.sv ----
// assertion checker for the selector privilege and coprocessor trap unit
`timescale 1ns/1ps
module spx_chk
  import spx_pkg::*;
#(
  parameter logic [7:0] VEC_PROT   = 8'h0D,
  parameter logic [7:0] VEC_NUMERR = 8'h10
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        npx_error,
  input wire logic        bus_lock,
  input wire logic        exc_valid,
  input wire logic [7:0]  exc_vector,
  input wire logic        npx_err_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////
  // decoded write and read strobes at the taking edge
  wire logic acc   = psel && penable && pready;
  wire logic wr    = acc && pwrite;
  wire logic wsel  = wr && paddr == SPX_SEL_OFS;
  wire logic wins  = wr && paddr == SPX_INSN_OFS;
  wire logic req_hi = pwdata[1:0] > pwdata[21:20];
  logic        ts_r;
  logic [15:0] adj_r;
  logic        zf_r;
  // shadow of the task-switched flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) ts_r <= 1'b0;
    else if (wins && (pwdata[1] || pwdata[2])) ts_r <= 1'b1;
    else if (wr && paddr == SPX_CTRL_OFS && pwdata[0]) ts_r <= 1'b0;
  end
  // expected adjust result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adj_r <= 16'h0000;
      zf_r  <= 1'b0;
    end
    else if (wr && paddr == SPX_ADJ_OFS)
    begin
      adj_r <= {pwdata[15:2], req_max(pwdata[1:0], pwdata[17:16])};
      zf_r  <= pwdata[17:16] > pwdata[1:0];
    end
  end
  function automatic logic [1:0] req_max(input logic [1:0] a, input logic [1:0] b);
    return (b > a) ? b : a;
  endfunction
  //////////////////////////////////////////////////////////////////////
  sel_fault_a: assert property (wsel && pwdata[18:16] < 3'h6 && req_hi |=>
    exc_valid && exc_vector == VEC_PROT) else $error("selector fault missing");
  sel_pass_a: assert property (wsel && !req_hi |=> !exc_valid)
    else $error("selector load faulted");
  ts_trap_a: assert property (wins && pwdata[0] && ts_r |=>
    exc_valid && exc_vector == 8'h07) else $error("not present trap missing");
  no_trap_a: assert property (wins && pwdata[5:0] == 6'h01 && !ts_r && !npx_error
    |=> !exc_valid) else $error("wait trapped without cause");
  err_ack_a: assert property (npx_err_ack |-> exc_valid && exc_vector == VEC_NUMERR
    && $past(wins && pwdata[0])) else $error("numeric error outside wait");
  tsw_quiet_a: assert property (wins && pwdata[5:0] == 6'h04 |=>
    !npx_err_ack && !exc_valid) else $error("task switch touched coprocessor");
  lock_tas_a: assert property (wins && pwdata[5:2] == 4'h2 |=>
    bus_lock [*3] ##1 !bus_lock) else $error("test and set lock length");
  lock_ack_a: assert property (wins && pwdata[5:2] == 4'h4 |=>
    bus_lock [*2] ##1 !bus_lock) else $error("acknowledge lock length");
  lock_desc_a: assert property (wins && pwdata[5:2] == 4'h8 |=>
    bus_lock [*4] ##1 !bus_lock) else $error("descriptor lock length");
  adj_read_a: assert property (acc && !pwrite && paddr == SPX_ADJ_OFS |->
    prdata[16:0] == {zf_r, adj_r}) else $error("adjust result wrong");
  cover property (wins && pwdata[0] && ts_r);
  cover property ($rose(bus_lock));
  cover property (npx_err_ack);
endmodule
bind spx_trap_unit spx_chk #(.VEC_PROT(VEC_PROT), .VEC_NUMERR(VEC_NUMERR)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .npx_error(npx_error), .bus_lock(bus_lock), .exc_valid(exc_valid),
  .exc_vector(exc_vector), .npx_err_ack(npx_err_ack));

// ---- testbench/spx_npx_model.sv ----
// numeric coprocessor model holding a pending error until acknowledged
`timescale 1ns/1ps
module spx_npx_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raise,
  input wire logic npx_err_ack,
  output logic     npx_error
);
  // error stays pending across task switches until the core takes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) npx_error <= 1'b0;
    else if (raise) npx_error <= 1'b1;
    else if (npx_err_ack) npx_error <= 1'b0;
  end
endmodule

// ---- testbench/tb.sv ----
// self-checking testbench for the selector privilege and coprocessor trap unit
`timescale 1ns/1ps
module tb
  import spx_pkg::*;
;
  localparam logic [7:0] PROT_V = 8'h0D;
  localparam logic [7:0] NUM_V  = 8'h10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, raise;
  logic npx_error, bus_lock, exc_valid, npx_err_ack, err_q;
  logic [7:0] paddr, exc_vector;
  logic [31:0] pwdata, prdata, rd_q;
  logic [11:0] mem_dpl;
  logic [5:0] cmd [5] = '{6'h08, 6'h10, 6'h20, 6'h04, 6'h38};
  int len [5] = '{3, 2, 4, 2, 9};
  int num_errors, comparisons, n;
  spx_trap_unit #(.VEC_PROT(PROT_V), .VEC_NUMERR(NUM_V)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .npx_error(npx_error), .mem_dpl(mem_dpl), .bus_lock(bus_lock),
    .exc_valid(exc_valid), .exc_vector(exc_vector), .npx_err_ack(npx_err_ack));
  spx_npx_model npx (.pclk(pclk), .presetn(presetn), .raise(raise),
    .npx_err_ack(npx_err_ack), .npx_error(npx_error));
  //////////////////////////////////////////////////////////////////////
  // clock generation
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, bounded wait for pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      num_errors++;
      final_report();
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    presetn = 1'b0; raise = 1'b0; mem_dpl = 12'h9E4; num_errors = 0; comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, SPX_STATUS_OFS, 32'h0000_0000);
    check("status reset", rd_q, 32'h0000_0000);
    xfer(1'b0, 8'h18, 32'h0000_0000);
    check("unmapped", {err_q, rd_q[30:0]}, 32'h8000_0000);
    xfer(1'b1, SPX_SEL_OFS, {10'h000, 2'h2, 1'b0, 3'h1, 16'h1232});
    xfer(1'b0, SPX_CACHE_OFS, 32'h0000_0000);
    check("cache load", rd_q & 32'h0030_FFFF, 32'h0020_1232);
    xfer(1'b1, SPX_SEL_OFS, {10'h000, 2'h2, 1'b0, 3'h3, 16'h0007});
    xfer(1'b0, SPX_STATUS_OFS, 32'h0000_0000);
    check("prot fault", rd_q & 32'h0000_0001, 32'h0000_0001);
    check("prot vector", {24'h00_0000, exc_vector}, {24'h00_0000, PROT_V});
    xfer(1'b1, SPX_CTRL_OFS, 32'h0000_0003);
    xfer(1'b0, SPX_CACHE_OFS, 32'h0000_0000);
    check("no load", rd_q, 32'h0000_0000);
    xfer(1'b1, SPX_STATUS_OFS, 32'h0000_0007);
    // every pair of destination and source privilege
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 4; j++)
      begin
        xfer(1'b1, SPX_ADJ_OFS, {14'h0000, j[1:0], 14'h1694, i[1:0]});
        xfer(1'b0, SPX_ADJ_OFS, 32'h0000_0000);
        check("adjust", rd_q & 32'h0001_FFFF, {15'h0000, j > i, 14'h1694,
          (j > i) ? j[1:0] : i[1:0]});
      end
    xfer(1'b1, SPX_INSN_OFS, 32'h0000_0001);
    xfer(1'b0, SPX_STATUS_OFS, 32'h0000_0000);
    check("wait clean", rd_q & 32'h0000_000F, 32'h0000_0000);
    xfer(1'b1, SPX_INSN_OFS, 32'h0000_0004);
    mem_dpl <= 12'h000;
    xfer(1'b0, SPX_STATUS_OFS, 32'h0000_0000);
    check("ts set", rd_q & 32'h0000_FF08, 32'h0000_0108);
    xfer(1'b1, SPX_CTRL_OFS, 32'h0000_0002);
    xfer(1'b0, SPX_CACHE_OFS, 32'h0000_0000);
    check("cache reload", rd_q & 32'h0030_0000, 32'h0020_0000);
    raise <= 1'b1;
    @(posedge pclk);
    raise <= 1'b0;
    xfer(1'b1, SPX_INSN_OFS, 32'h0000_0001);
    xfer(1'b0, SPX_STATUS_OFS, 32'h0000_0000);
    check("ts trap", {rd_q[23:0] & 24'h00_000E, exc_vector}, 32'h0000_0A07);
    check("error kept", {31'h0000_0000, npx_error}, 32'h0000_0001);
    xfer(1'b1, SPX_CTRL_OFS, 32'h0000_0001);
    xfer(1'b1, SPX_INSN_OFS, 32'h0000_0001);
    xfer(1'b0, SPX_STATUS_OFS, 32'h0000_0000);
    check("num trap", {rd_q[23:0] & 24'h00_000E, exc_vector}, {24'h00_0006, NUM_V});
    check("error taken", {31'h0000_0000, npx_error}, 32'h0000_0000);
    // locked sequences, lengths summed per command
    for (int c = 0; c < 5; c++)
    begin
      xfer(1'b1, SPX_INSN_OFS, {26'h000_0000, cmd[c]});
      n = 0;
      repeat (16)
      begin
        @(posedge pclk);
        if (bus_lock === 1'b1) n++;
      end
      check("lock len", n, len[c]);
    end
    // instruction write held off until the running lock ends
    xfer(1'b1, SPX_INSN_OFS, 32'h0000_0020);
    xfer(1'b1, SPX_INSN_OFS, 32'h0000_0008);
    n = 0;
    repeat (16)
    begin
      @(posedge pclk);
      if (bus_lock === 1'b1) n++;
    end
    check("lock stall", n, 3);
    final_report();
  end
endmodule
